//--- inc/fsg_pkg.sv
package fsg_pkg;

	////////////////////////////////////////////////////////////////////////
	// Function codes
	localparam logic [7:0] FN_REL_LINE = 8'h56;
	localparam logic [7:0] FN_REL_MOVE = 8'h57;
	localparam logic [7:0] FN_FILL     = 8'h58;
	localparam logic [7:0] FN_RGB      = 8'h59;
	localparam logic [7:0] FN_BITMAP   = 8'h5a;
	localparam logic [7:0] FN_ELLIPSE  = 8'h5b;
	localparam logic [7:0] FN_RECT     = 8'h5c;
	localparam logic [7:0] FN_YUV      = 8'h5d;

	////////////////////////////////////////////////////////////////////////
	// Drawing area and parameter counts
	localparam logic signed [11:0] AREA_W  = 12'h168;
	localparam logic signed [11:0] AREA_H  = 12'h12c;
	localparam logic [1:0]         NP_XY   = 2'h3;
	localparam logic [1:0]         NP_COL  = 2'h2;
	localparam logic [1:0]         NP_SECT = 2'h0;

	////////////////////////////////////////////////////////////////////////
	// Reset colour (white) and colour conversion
	localparam logic [7:0] WHITE_Y = 8'heb;
	localparam logic [7:0] WHITE_U = 8'h80;
	localparam logic [7:0] WHITE_V = 8'h80;
	localparam logic signed [17:0] K_YR = 18'h00042;
	localparam logic signed [17:0] K_YG = 18'h00081;
	localparam logic signed [17:0] K_YB = 18'h00019;
	localparam logic signed [17:0] K_UR = 18'h3ffda;
	localparam logic signed [17:0] K_UG = 18'h3ffb6;
	localparam logic signed [17:0] K_UB = 18'h00070;
	localparam logic signed [17:0] K_VR = 18'h00070;
	localparam logic signed [17:0] K_VG = 18'h3ffa2;
	localparam logic signed [17:0] K_VB = 18'h3ffee;
	localparam logic signed [17:0] K_RND = 18'h00080;
	localparam logic [7:0]         Y_OFS = 8'h10;
	localparam logic [7:0]         C_OFS = 8'h80;

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef logic signed [11:0] fsg_coord_t;

	typedef struct packed {
		logic [7:0] y;
		logic [7:0] u;
		logic [7:0] v;
	} fsg_colour_t;

	typedef struct packed {
		logic [7:0] r;
		logic [7:0] g;
		logic [7:0] b;
	} fsg_rgb_t;

	typedef struct packed {
		logic        page;
		logic [8:0]  x;
		logic [8:0]  y;
		logic [31:0] data;
	} fsg_pix_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_PARAM = 3'h1,
		ST_EXEC  = 3'h3,
		ST_SCAN  = 3'h2,
		ST_LINE  = 3'h6,
		ST_NAME  = 3'h7,
		ST_HDR   = 3'h5
	} fsg_state_t;

	typedef enum logic [1:0] {
		SM_FILL = 2'h0,
		SM_RECT = 2'h1,
		SM_ELL  = 2'h2,
		SM_BM   = 2'h3
	} fsg_smode_t;

endpackage

//--- verilog/fsg_rgb2yuv.sv
module fsg_rgb2yuv (
	input  fsg_pkg::fsg_rgb_t    rgb,
	output fsg_pkg::fsg_colour_t yuv
);
	import fsg_pkg::*;

	logic signed [17:0] r_s, g_s, b_s, y_s, u_s, v_s;

	always_comb begin
		r_s = {10'h0, rgb.r};
		g_s = {10'h0, rgb.g};
		b_s = {10'h0, rgb.b};
		y_s = K_YR * r_s + K_YG * g_s + K_YB * b_s + K_RND;
		u_s = K_UR * r_s + K_UG * g_s + K_UB * b_s + K_RND;
		v_s = K_VR * r_s + K_VG * g_s + K_VB * b_s + K_RND;
		yuv.y = y_s[15:8] + Y_OFS;
		yuv.u = u_s[15:8] + C_OFS;
		yuv.v = v_s[15:8] + C_OFS;
	end

endmodule

//--- verilog/fsg_engine.sv
// Functional notes
// - Code 86 draws relative line if target inside
// - Code 87 moves cursor relative, else unchanged
// - Code 88 fills selected page with colour
// - Code 89 converts RGB to colour, stores
// - Code 90 plots flash bitmap ones in colour
// - Bitmap zero pixels leave store untouched
// - Flash names matched case-sensitively
// - Later bitmaps overwrite earlier ones
// - Code 91 ellipse around cursor, cursor kept
// - Code 92 filled rectangle, then cursor moves
// - Rectangle past area draws nothing, cursor kept
// - Code 93 sets colour from YUV bytes
// - Coordinates bounded to 360 by 300
// - Colour and cursor kept per page
// - Store pixels as 4:2:2 luma/chroma words
module fsg_engine (
	input  logic                  sys_clk,
	input  logic                  nrst,
	input  logic                  page_sel,
	input  logic                  cmd_valid,
	input  logic [7:0]            cmd_byte,
	output logic                  cmd_ready,
	output logic                  px_valid,
	output fsg_pkg::fsg_pix_t     px,
	input  logic                  px_ready,
	output logic                  fl_req,
	output logic [7:0]            fl_sector,
	output logic                  fl_name_valid,
	output logic [7:0]            fl_name_char,
	output logic                  fl_name_last,
	input  logic                  fl_hdr_valid,
	input  logic                  fl_found,
	input  logic [9:0]            fl_width,
	input  logic [9:0]            fl_height,
	input  logic                  fl_bit_valid,
	input  logic                  fl_bit,
	output logic                  fl_bit_ready,
	output logic                  busy
);
	import fsg_pkg::*;

	logic          rst_m_n, rst_n;
	fsg_state_t    state_q;
	fsg_smode_t    mode_q;
	logic [7:0]    code_q;
	logic [7:0]    p_q [4];
	logic [1:0]    cnt_q, need_q;
	logic          page_q;
	logic [8:0]    cur_x_q [2];
	logic [8:0]    cur_y_q [2];
	fsg_colour_t   col_q [2];
	fsg_colour_t   rgb_yuv;
	fsg_coord_t    sx_q, sy_q, x0_q, x1_q, y1_q, ecx_q, ecy_q;
	fsg_coord_t    lx_q, ly_q, ltx_q, lty_q, ldx_q, ldy_q;
	logic signed [12:0] err_q, e2;
	logic          lsx_q, lsy_q;
	logic [15:0]   a2_q, b2_q;
	logic [31:0]   ab2_q;
	logic          pv_q;
	fsg_pix_t      px_q;
	logic          take, adv, exec, scan_step, line_step, hit, last, vis;
	logic signed [16:0] tx, ty, rx_end, ry_end;
	logic          tgt_ok, rect_ok;
	fsg_coord_t    pxx, pxy;
	logic [8:0]    ux, uy;

	////////////////////////////////////////////////////////////////////////
	// Reset release
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rst_m_n <= 1'b0;
			rst_n   <= 1'b0;
		end else begin
			rst_m_n <= 1'b1;
			rst_n   <= rst_m_n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Decode helpers
	function automatic logic in_ell(input logic [8:0] x, input logic [8:0] y,
			input logic [15:0] a2, input logic [15:0] b2, input logic [31:0] ab2);
		logic [35:0] s;
		s = 36'(x) * 36'(x) * 36'(b2) + 36'(y) * 36'(y) * 36'(a2);
		return s <= 36'(ab2);
	endfunction

	assign take = cmd_valid && cmd_ready;
	assign adv  = !pv_q || px_ready;
	assign exec = (state_q == ST_EXEC);
	assign cmd_ready = !pv_q && (state_q == ST_IDLE || state_q == ST_PARAM ||
		state_q == ST_NAME);
	assign busy = (state_q != ST_IDLE) || pv_q;
	// High byte first, two's complement
	assign tx = 17'(signed'({8'h0, cur_x_q[page_q]})) + 17'(signed'({p_q[0], p_q[1]}));
	assign ty = 17'(signed'({8'h0, cur_y_q[page_q]})) + 17'(signed'({p_q[2], p_q[3]}));
	assign rx_end = 17'({8'h0, cur_x_q[page_q]}) + 17'({p_q[0], p_q[1]});
	assign ry_end = 17'({8'h0, cur_y_q[page_q]}) + 17'({p_q[2], p_q[3]});
	assign tgt_ok = tx >= 0 && tx < 17'(AREA_W) && ty >= 0 && ty < 17'(AREA_H);
	assign rect_ok = {p_q[0], p_q[1]} != 16'h0 && {p_q[2], p_q[3]} != 16'h0 &&
		!p_q[0][7] && !p_q[2][7] &&
		rx_end <= 17'(AREA_W) && ry_end <= 17'(AREA_H);

	assign pxx = (state_q == ST_LINE) ? lx_q : sx_q;
	assign pxy = (state_q == ST_LINE) ? ly_q : sy_q;
	assign vis = pxx >= 0 && pxx < AREA_W && pxy >= 0 && pxy < AREA_H;
	assign ux  = (sx_q < ecx_q) ? 9'(ecx_q - sx_q) : 9'(sx_q - ecx_q);
	assign uy  = (sy_q < ecy_q) ? 9'(ecy_q - sy_q) : 9'(sy_q - ecy_q);
	assign scan_step = state_q == ST_SCAN && adv && (mode_q != SM_BM || fl_bit_valid);
	assign line_step = state_q == ST_LINE && adv;
	assign fl_bit_ready = state_q == ST_SCAN && mode_q == SM_BM && adv;
	assign last = sx_q == x1_q && sy_q == y1_q;
	assign e2   = err_q <<< 1;

	always_comb begin
		case (mode_q)
			SM_BM:   hit = vis && fl_bit;
			SM_ELL:  hit = vis && in_ell(ux, uy, a2_q, b2_q, ab2_q) &&
				!(in_ell(ux + 9'h1, uy, a2_q, b2_q, ab2_q) &&
				in_ell(ux, uy + 9'h1, a2_q, b2_q, ab2_q));
			default: hit = vis;
		endcase
	end

	fsg_rgb2yuv u_conv (
		.rgb ({p_q[0], p_q[1], p_q[2]}),
		.yuv (rgb_yuv)
	);

	////////////////////////////////////////////////////////////////////////
	// Command byte collection
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			code_q  <= 8'h0;
			cnt_q   <= 2'h0;
			need_q  <= 2'h0;
			page_q  <= 1'b0;
			for (int i = 0; i < 4; i++) p_q[i] <= 8'h0;
		end else begin
			case (state_q)
				ST_IDLE: if (take) begin
					code_q <= cmd_byte;
					page_q <= page_sel;
					cnt_q  <= 2'h0;
					case (cmd_byte)
						FN_REL_LINE, FN_REL_MOVE, FN_ELLIPSE, FN_RECT: begin
							need_q  <= NP_XY;
							state_q <= ST_PARAM;
						end
						FN_RGB, FN_YUV: begin
							need_q  <= NP_COL;
							state_q <= ST_PARAM;
						end
						FN_BITMAP: begin
							need_q  <= NP_SECT;
							state_q <= ST_PARAM;
						end
						FN_FILL: state_q <= ST_EXEC;
						default: state_q <= ST_IDLE;
					endcase
				end
				ST_PARAM: if (take) begin
					p_q[cnt_q] <= cmd_byte;
					cnt_q      <= cnt_q + 2'h1;
					if (cnt_q == need_q)
						state_q <= (code_q == FN_BITMAP) ? ST_NAME : ST_EXEC;
				end
				ST_NAME: if (take && cmd_byte == 8'h0) state_q <= ST_HDR;
				ST_HDR: if (fl_hdr_valid)
					state_q <= (fl_found && fl_width != 10'h0 && fl_height != 10'h0) ?
						ST_SCAN : ST_IDLE;
				ST_EXEC: begin
					case (code_q)
						FN_REL_LINE: state_q <= tgt_ok ? ST_LINE : ST_IDLE;
						FN_FILL, FN_ELLIPSE: state_q <= ST_SCAN;
						FN_RECT: state_q <= rect_ok ? ST_SCAN : ST_IDLE;
						default: state_q <= ST_IDLE;
					endcase
				end
				ST_SCAN: if (scan_step && last) state_q <= ST_IDLE;
				ST_LINE: if (line_step && lx_q == ltx_q && ly_q == lty_q)
					state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Flash request, names passed unaltered
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fl_req        <= 1'b0;
			fl_sector     <= 8'h0;
			fl_name_valid <= 1'b0;
			fl_name_char  <= 8'h0;
			fl_name_last  <= 1'b0;
		end else begin
			fl_req        <= state_q == ST_PARAM && take && code_q == FN_BITMAP;
			fl_name_valid <= state_q == ST_NAME && take;
			if (state_q == ST_PARAM && take && code_q == FN_BITMAP) fl_sector <= cmd_byte;
			if (state_q == ST_NAME && take) begin
				fl_name_char <= cmd_byte;
				fl_name_last <= cmd_byte == 8'h0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-page colour and cursor
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 2; i++) col_q[i] <= '{WHITE_Y, WHITE_U, WHITE_V};
		end else if (exec && code_q == FN_RGB) begin
			col_q[page_q] <= rgb_yuv;
		end else if (exec && code_q == FN_YUV) begin
			col_q[page_q] <= '{p_q[0], p_q[1], p_q[2]};
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 2; i++) begin
				cur_x_q[i] <= 9'h0;
				cur_y_q[i] <= 9'h0;
			end
		end else if (exec && (code_q == FN_REL_MOVE || code_q == FN_REL_LINE) && tgt_ok) begin
			cur_x_q[page_q] <= tx[8:0];
			cur_y_q[page_q] <= ty[8:0];
		end else if (scan_step && last && mode_q == SM_RECT) begin
			cur_x_q[page_q] <= 9'(x1_q + 12'h1);
			cur_y_q[page_q] <= 9'(y1_q + 12'h1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Raster scan for fill, rectangle, ellipse and bitmap
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= SM_FILL;
			{sx_q, sy_q, x0_q, x1_q, y1_q, ecx_q, ecy_q} <= '0;
			{a2_q, b2_q, ab2_q} <= '0;
		end else if (exec) begin
			ecx_q <= 12'(cur_x_q[page_q]);
			ecy_q <= 12'(cur_y_q[page_q]);
			a2_q  <= 16'(p_q[1]) * 16'(p_q[1]);
			b2_q  <= 16'(p_q[3]) * 16'(p_q[3]);
			ab2_q <= 32'(p_q[1]) * 32'(p_q[1]) * 32'(p_q[3]) * 32'(p_q[3]);
			case (code_q)
				FN_FILL: begin
					mode_q <= SM_FILL;
					{sx_q, sy_q, x0_q} <= '0;
					x1_q <= AREA_W - 12'h1;
					y1_q <= AREA_H - 12'h1;
				end
				FN_ELLIPSE: begin
					mode_q <= SM_ELL;
					sx_q <= 12'(cur_x_q[page_q]) - 12'(p_q[1]);
					x0_q <= 12'(cur_x_q[page_q]) - 12'(p_q[1]);
					x1_q <= 12'(cur_x_q[page_q]) + 12'(p_q[1]);
					sy_q <= 12'(cur_y_q[page_q]) - 12'(p_q[3]);
					y1_q <= 12'(cur_y_q[page_q]) + 12'(p_q[3]);
				end
				default: begin
					mode_q <= SM_RECT;
					sx_q <= 12'(cur_x_q[page_q]);
					x0_q <= 12'(cur_x_q[page_q]);
					sy_q <= 12'(cur_y_q[page_q]);
					x1_q <= 12'(rx_end) - 12'h1;
					y1_q <= 12'(ry_end) - 12'h1;
				end
			endcase
		end else if (state_q == ST_HDR && fl_hdr_valid) begin
			mode_q <= SM_BM;
			sx_q <= 12'(cur_x_q[page_q]);
			x0_q <= 12'(cur_x_q[page_q]);
			sy_q <= 12'(cur_y_q[page_q]);
			x1_q <= 12'(cur_x_q[page_q]) + 12'(fl_width) - 12'h1;
			y1_q <= 12'(cur_y_q[page_q]) + 12'(fl_height) - 12'h1;
		end else if (scan_step && !last) begin
			sx_q <= (sx_q == x1_q) ? x0_q : sx_q + 12'h1;
			sy_q <= (sx_q == x1_q) ? sy_q + 12'h1 : sy_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Line stepping
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			{lx_q, ly_q, ltx_q, lty_q, ldx_q, ldy_q} <= '0;
			err_q <= '0;
			{lsx_q, lsy_q} <= 2'h0;
		end else if (exec && code_q == FN_REL_LINE) begin
			lx_q  <= 12'(cur_x_q[page_q]);
			ly_q  <= 12'(cur_y_q[page_q]);
			ltx_q <= 12'(tx);
			lty_q <= 12'(ty);
			lsx_q <= p_q[0][7];
			lsy_q <= p_q[2][7];
			ldx_q <= 12'(p_q[0][7] ? -tx + 17'(cur_x_q[page_q]) : tx - 17'(cur_x_q[page_q]));
			ldy_q <= 12'(p_q[2][7] ? ty - 17'(cur_y_q[page_q]) : -ty + 17'(cur_y_q[page_q]));
			err_q <= 13'(p_q[0][7] ? -tx + 17'(cur_x_q[page_q]) : tx - 17'(cur_x_q[page_q])) +
				13'(p_q[2][7] ? ty - 17'(cur_y_q[page_q]) : -ty + 17'(cur_y_q[page_q]));
		end else if (line_step) begin
			err_q <= err_q + ((e2 >= 13'(ldy_q)) ? 13'(ldy_q) : 13'h0) +
				((e2 <= 13'(ldx_q)) ? 13'(ldx_q) : 13'h0);
			if (e2 >= 13'(ldy_q)) lx_q <= lsx_q ? lx_q - 12'h1 : lx_q + 12'h1;
			if (e2 <= 13'(ldx_q)) ly_q <= lsy_q ? ly_q - 12'h1 : ly_q + 12'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pixel write port, 4:2:2 pair word
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pv_q <= 1'b0;
			px_q <= '0;
		end else if (adv) begin
			pv_q <= (scan_step && hit) || (line_step && vis);
			px_q.page <= page_q;
			px_q.x    <= pxx[8:0];
			px_q.y    <= pxy[8:0];
			px_q.data <= {col_q[page_q].y, col_q[page_q].u,
				col_q[page_q].y, col_q[page_q].v};
		end
	end

	assign px_valid = pv_q;
	assign px       = px_q;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_rect_last;
		scan_step && last && mode_q == SM_RECT;
	endsequence

	chk_move_reject: assert property (exec && code_q == FN_REL_MOVE && !tgt_ok |=>
		cur_x_q[page_q] == $past(cur_x_q[page_q]) && cur_y_q[page_q] == $past(cur_y_q[page_q]))
		else $error("cursor moved off area");
	chk_move_apply: assert property (exec && code_q == FN_REL_MOVE && tgt_ok |=>
		cur_x_q[page_q] == $past(tx[8:0])) else $error("relative move lost");
	chk_pix_area: assert property (pv_q |-> px_q.x < 9'h168 && px_q.y < 9'h12c)
		else $error("pixel outside area");
	chk_yuv_store: assert property (exec && code_q == FN_YUV |=>
		col_q[page_q].y == $past(p_q[0]) && col_q[page_q].v == $past(p_q[2]))
		else $error("yuv colour not stored");
	chk_fill_start: assert property (exec && code_q == FN_FILL |=>
		state_q == ST_SCAN ##1 (pv_q || !px_ready)) else $error("fill did not start");
	chk_rect_reject: assert property (exec && code_q == FN_RECT && !rect_ok |=>
		state_q == ST_IDLE && !pv_q ##1 !pv_q) else $error("bad rectangle drawn");
	chk_rect_cursor: assert property (s_rect_last |=>
		cur_x_q[page_q] == 9'($past(x1_q) + 12'h1)) else $error("rectangle cursor wrong");
	chk_bm_zero: assert property (fl_bit_ready && fl_bit_valid && !fl_bit |=> !pv_q)
		else $error("zero bitmap pixel written");
	chk_ell_cursor: assert property (state_q == ST_SCAN && mode_q == SM_ELL |=>
		$stable(cur_x_q[page_q]) && $stable(cur_y_q[page_q])) else $error("ellipse moved cursor");
	chk_pix_colour: assert property (pv_q |-> px_q.data[31:24] == col_q[px_q.page].y)
		else $error("pixel colour mismatch");

endmodule

//--- bench/fsg_store_model.sv
module fsg_store_model (
	input  logic       sys_clk,
	input  logic       slow,
	input  logic       px_valid,
	output logic       px_ready,
	input  logic       fl_name_valid,
	input  logic [7:0] fl_name_char,
	input  logic       fl_name_last,
	output logic       fl_hdr_valid,
	output logic       fl_found,
	output logic [9:0] fl_width,
	output logic [9:0] fl_height,
	output logic       fl_bit_valid,
	output logic       fl_bit,
	input  logic       fl_bit_ready
);
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////
	// Stored bitmap: 3 wide, 2 tall, first bit in bit 0
	localparam logic [5:0] PAT = 6'h35;

	logic [15:0] name_q = 16'h0;
	logic [2:0]  bit_q  = 3'h0;
	logic        arm_q  = 1'b0;
	logic [1:0]  cyc_q  = 2'h0;
	logic        hdr_q  = 1'b0;
	logic        fnd_q  = 1'b0;

	assign fl_hdr_valid = hdr_q;
	assign fl_found     = fnd_q;
	assign fl_width     = 10'h3;
	assign fl_height    = 10'h2;
	assign px_ready     = !slow || cyc_q[0];
	assign fl_bit_valid = arm_q && (!slow || cyc_q[1]);
	// Released data line shows the inverse of the held bit
	assign fl_bit       = fl_bit_valid ? PAT[bit_q] : !PAT[bit_q];

	////////////////////////////////////////////////////////////////////////
	// Name lookup, exact byte match only
	always @(posedge sys_clk) begin
		cyc_q <= cyc_q + 2'h1;
		hdr_q <= 1'b0;
		if (fl_name_valid && !fl_name_last) begin
			name_q <= {name_q[7:0], fl_name_char};
		end
		if (fl_name_valid && fl_name_last) begin
			hdr_q <= 1'b1;
			fnd_q <= (name_q == 16'h4162);
			arm_q <= (name_q == 16'h4162);
			name_q <= 16'h0;
			bit_q <= 3'h0;
		end
		if (fl_bit_valid && fl_bit_ready) begin
			bit_q <= (bit_q == 3'h5) ? 3'h0 : bit_q + 3'h1;
			if (bit_q == 3'h5) begin
				arm_q <= 1'b0;
			end
		end
	end
endmodule

//--- bench/tb_frame_store_graphics_commands.sv
module tb_frame_store_graphics_commands;
	timeunit 1ns;
	timeprecision 1ps;
	import fsg_pkg::*;

	logic       sys_clk, nrst, page_sel, cmd_valid, cmd_ready, px_valid, px_ready;
	logic [7:0] cmd_byte, fl_sector, fl_name_char;
	fsg_pix_t   px;
	logic       fl_req, fl_name_valid, fl_name_last, fl_hdr_valid, fl_found;
	logic [9:0] fl_width, fl_height;
	logic       fl_bit_valid, fl_bit, fl_bit_ready, busy, slow, pg;
	int         miscompares, checks_done, fl_reqs, cx, cy;
	logic [31:0] col0;
	fsg_pix_t   pq[$];

	fsg_engine u_dut (
		.sys_clk      (sys_clk),      .nrst         (nrst),
		.page_sel     (page_sel),     .cmd_valid    (cmd_valid),
		.cmd_byte     (cmd_byte),     .cmd_ready    (cmd_ready),
		.px_valid     (px_valid),     .px           (px),
		.px_ready     (px_ready),     .fl_req       (fl_req),
		.fl_sector    (fl_sector),    .fl_name_valid(fl_name_valid),
		.fl_name_char (fl_name_char), .fl_name_last (fl_name_last),
		.fl_hdr_valid (fl_hdr_valid), .fl_found     (fl_found),
		.fl_width     (fl_width),     .fl_height    (fl_height),
		.fl_bit_valid (fl_bit_valid), .fl_bit       (fl_bit),
		.fl_bit_ready (fl_bit_ready), .busy         (busy)
	);

	fsg_store_model u_store (
		.sys_clk(sys_clk), .slow(slow), .px_valid(px_valid), .px_ready(px_ready),
		.fl_name_valid(fl_name_valid), .fl_name_char(fl_name_char),
		.fl_name_last(fl_name_last), .fl_hdr_valid(fl_hdr_valid), .fl_found(fl_found),
		.fl_width(fl_width), .fl_height(fl_height), .fl_bit_valid(fl_bit_valid),
		.fl_bit(fl_bit), .fl_bit_ready(fl_bit_ready)
	);

	always #5 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		if (px_valid && px_ready) pq.push_back(px);
		if (fl_req) fl_reqs++;
	end

	////////////////////////////////////////////////////////////////////////
	// Helpers
	task finish_test;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task run(input logic [7:0] q[$]);
		logic r;
		int   n;
		@(posedge sys_clk);
		for (int i = 0; i < q.size(); i++) begin
			cmd_valid <= 1'b1;
			cmd_byte <= q[i];
			r = 1'b0;
			while (!r) begin
				@(negedge sys_clk);
				r = cmd_ready;
				@(posedge sys_clk);
			end
		end
		cmd_valid <= 1'b0;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while ((busy !== 1'b0 || px_valid !== 1'b0) && n < 3000);
		chk("command done", 32'h1, 32'(n < 3000));
	endtask

	task cmd4(input logic [7:0] c, input logic [15:0] a, input logic [15:0] b);
		run({c, a[15:8], a[7:0], b[15:8], b[7:0]});
	endtask

	task cmd3(input logic [7:0] c, input logic [7:0] a, b, d);
		run({c, a, b, d});
	endtask

	task px_chk(input int i, input int x, input int y, input logic [31:0] d);
		chk("pixel x", 32'(x), {23'h0, pq[i].x});
		chk("pixel y", 32'(y), {23'h0, pq[i].y});
		chk("pixel page", {31'h0, pg}, {31'h0, pq[i].page});
		chk("pixel data", d, pq[i].data);
	endtask

	task cnt(input int n);
		chk("pixel count", 32'(n), 32'(pq.size()));
	endtask

	task one_px;
		pq.delete();
		cmd4(FN_RECT, 16'h1, 16'h1);
		cnt(1);
		px_chk(0, cx, cy, col0);
		cx++;
		cy++;
	endtask

	function automatic logic [31:0] rgbw(int r, int g, int b);
		int y, u, v;
		y = ((66 * r + 129 * g + 25 * b + 128) >>> 8) + 16;
		u = ((-38 * r - 74 * g + 112 * b + 128) >>> 8) + 128;
		v = ((112 * r - 94 * g - 18 * b + 128) >>> 8) + 128;
		return {y[7:0], u[7:0], y[7:0], v[7:0]};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task t_move;
		cmd4(FN_REL_MOVE, 16'd10, 16'd5);
		cmd4(FN_REL_MOVE, 16'hff9c, 16'h0);
		pq.delete();
		cmd4(FN_RECT, 16'h2, 16'h2);
		cnt(4);
		px_chk(0, 10, 5, col0);
		px_chk(3, 11, 6, col0);
		cx = 12;
		cy = 7;
		one_px();
	endtask

	task t_rect_out;
		pq.delete();
		cmd4(FN_RECT, 16'd348, 16'h1);
		cmd4(FN_RECT, 16'h1, 16'd293);
		cnt(0);
		one_px();
	endtask

	task t_colour;
		int t[3][3];
		t = '{'{255, 0, 0}, '{0, 255, 0}, '{12, 34, 200}};
		cmd3(FN_YUV, 8'h0a, 8'h14, 8'h1e);
		col0 = 32'h0a140a1e;
		one_px();
		for (int i = 0; i < 3; i++) begin
			cmd3(FN_RGB, 8'(t[i][0]), 8'(t[i][1]), 8'(t[i][2]));
			col0 = rgbw(t[i][0], t[i][1], t[i][2]);
			one_px();
		end
	endtask

	task t_line;
		@(posedge sys_clk) slow <= 1'b1;
		pq.delete();
		cmd4(FN_REL_LINE, 16'h3, 16'h0);
		cnt(4);
		px_chk(0, cx, cy, col0);
		px_chk(3, cx + 3, cy, col0);
		cx += 3;
		pq.delete();
		cmd4(FN_REL_LINE, 16'h0, 16'hffff);
		cnt(2);
		px_chk(1, cx, cy - 1, col0);
		cy -= 1;
		pq.delete();
		cmd4(FN_REL_LINE, 16'hfe70, 16'h0);
		cnt(0);
		one_px();
	endtask

	task t_page;
		@(posedge sys_clk) page_sel <= 1'b1;
		pg = 1'b1;
		cmd3(FN_YUV, 8'h01, 8'h02, 8'h03);
		pq.delete();
		cmd4(FN_RECT, 16'h1, 16'h1);
		cnt(1);
		px_chk(0, 0, 0, 32'h01020103);
		@(posedge sys_clk) page_sel <= 1'b0;
		pg = 1'b0;
		one_px();
	endtask

	task t_ellipse;
		int bad;
		pq.delete();
		cmd4(FN_ELLIPSE, 16'h2, 16'h2);
		chk("ellipse drawn", 32'h1, 32'(pq.size() > 0));
		bad = 0;
		foreach (pq[i]) begin
			if (pq[i].x < cx - 2 || pq[i].x > cx + 2 || pq[i].y < cy - 2 || pq[i].y > cy + 2)
				bad++;
		end
		chk("ellipse outside box", 32'h0, 32'(bad));
		one_px();
	endtask

	task bm(input logic [7:0] a, input logic [7:0] b);
		pq.delete();
		fl_reqs = 0;
		run({FN_BITMAP, 8'h05, a, b, 8'h00});
		chk("flash request", 32'h1, 32'(fl_reqs));
		chk("flash sector", 32'h5, {24'h0, fl_sector});
	endtask

	task bm_chk;
		cnt(4);
		px_chk(0, cx, cy, col0);
		px_chk(1, cx + 2, cy, col0);
		px_chk(2, cx + 1, cy + 1, col0);
		px_chk(3, cx + 2, cy + 1, col0);
	endtask

	task t_bitmap;
		bm(8'h41, 8'h62);
		bm_chk();
		bm(8'h61, 8'h42);
		cnt(0);
		cmd3(FN_YUV, 8'h50, 8'h5a, 8'ha0);
		col0 = 32'h505a50a0;
		bm(8'h41, 8'h62);
		bm_chk();
	endtask

	task t_fill;
		int n;
		@(posedge sys_clk) slow <= 1'b0;
		pq.delete();
		cmd_valid <= 1'b1;
		cmd_byte  <= FN_FILL;
		@(negedge sys_clk);
		chk("fill code ready", 32'h1, {31'h0, cmd_ready});
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		n = 0;
		while (pq.size() < 362 && n < 1000) begin
			@(negedge sys_clk);
			n++;
		end
		px_chk(0, 0, 0, col0);
		px_chk(359, 359, 0, col0);
		px_chk(360, 0, 1, col0);
		chk("fill still busy", 32'h1, {31'h0, busy});
		// Reset in mid-fill: cursor and colour back to defaults
		@(posedge sys_clk) nrst <= 1'b0;
		repeat (16) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk("busy after reset", 32'h0, {31'h0, busy});
		col0 = {WHITE_Y, WHITE_U, WHITE_Y, WHITE_V};
		cx = 0;
		cy = 0;
		one_px();
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence and watchdog
	initial begin
		sys_clk = 1'b0;
		nrst = 1'b0;
		page_sel = 1'b0;
		cmd_valid = 1'b0;
		cmd_byte = 8'h0;
		slow = 1'b0;
		pg = 1'b0;
		col0 = {WHITE_Y, WHITE_U, WHITE_Y, WHITE_V};
		cx = 0;
		cy = 0;
		repeat (16) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge sys_clk);
		t_move();
		t_rect_out();
		t_colour();
		t_line();
		t_page();
		t_ellipse();
		t_bitmap();
		t_fill();
		finish_test();
	end

	initial begin
		repeat (30000) @(posedge sys_clk);
		miscompares++;
		finish_test();
	end
endmodule
